//--- bpi_pkg.sv
// constants for the backplane master/slave bus interface
package bpi_pkg;
  localparam int CLK_MHZ = 25;
  // processor half period; the processor clock is derived by a divider
  localparam int PROC_HALF_NS = 80;
  localparam int PROC_HALF_CYC = (PROC_HALF_NS * CLK_MHZ + 999) / 1000;
  // power settling time before bus reset is released
  localparam int PWR_SETTLE_US = 10000;
  localparam int PWR_SETTLE_CYC = PWR_SETTLE_US * CLK_MHZ;
  // shift chain layout
  localparam int CHAIN_DEPTH = 4;
  localparam int TAP_SYNC = 0;
  localparam int TAP_STVAL = 1;
  localparam int TAP_HOLD = 2;
  // bus widths
  localparam int ADDR_W = 24;
  localparam int CPU_ADDR_W = 16;
  localparam int LOW_ADDR_W = 12;
  localparam int MAP_W = 12;
  localparam int SEL_W = 8;
  localparam int DATA_W = 8;
  localparam int WAIT_W = 3;
  localparam logic [WAIT_W-1:0] WAIT_MAX = 3'h5;
  localparam logic [WAIT_W-1:0] WAIT_NONE = 3'h0;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 24'h000000;
  typedef enum logic [2:0] {
    SLV_IDLE = 3'b001,
    SLV_WAIT = 3'b010,
    SLV_DONE = 3'b100
  } bpi_slv_e;
endpackage

//--- bpi_tap_chain.sv
// flip-flop shift chain whose taps give fixed relative delays
module bpi_tap_chain #(
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // shift
  input wire logic shiftEn,
  input wire logic din,
  // taps
  output logic [DEPTH-1:0] taps
);
  logic [DEPTH-1:0] next_taps;

  initial begin
    if (DEPTH < 3) $error("tap chain too short");
  end

  always_comb begin
    next_taps = taps;
    if (shiftEn) begin
      next_taps = {taps[DEPTH-2:0], din};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      taps <= '0;
    end else begin
      taps <= next_taps;
    end
  end
endmodule

//--- bpi_ram.sv
// single-port on-board RAM with registered read data
module bpi_ram #(
  parameter int AW = 16,
  parameter int DW = 8
) (
  // clock
  input wire logic clk,
  // access
  input wire logic en,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  initial begin
    if (AW < 1 || DW < 1) $error("ram size invalid");
  end

  always_ff @(posedge clk) begin
    if (en) begin
      if (we) begin
        mem[addr] <= wdata;
      end
      rdata <= mem[addr];
    end
  end
endmodule

//--- bpi_bus_if.sv
// backplane bus interface: master timing, reset sequencing, slave decode
module bpi_bus_if #(
  parameter int SETTLE_CYC = bpi_pkg::PWR_SETTLE_CYC,
  parameter int RAM_AW = bpi_pkg::CPU_ADDR_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // straps and switches
  input wire logic masterSlaveSelectStrap,
  input wire logic slaveWaitFitted,
  input wire logic [bpi_pkg::WAIT_W-1:0] slaveWaitCountStrap,
  input wire logic [bpi_pkg::SEL_W-1:0] boardSelSwitch,
  // power and manual reset pins
  input wire logic pwrGood,
  input wire logic resetBtnN,
  // processor side
  input wire logic cpuMreqN,
  input wire logic cpuIorqN,
  input wire logic cpuRdN,
  input wire logic cpuWrN,
  input wire logic cpuM1N,
  input wire logic cpuRamSel,
  input wire logic [bpi_pkg::CPU_ADDR_W-1:0] cpuAddr,
  input wire logic [bpi_pkg::DATA_W-1:0] cpuWdata,
  input wire logic [bpi_pkg::MAP_W-1:0] mapAddr,
  output logic procClk,
  output logic boardRst,
  output logic [bpi_pkg::DATA_W-1:0] cpuRdata,
  // bus status and control outputs
  output logic busPhiOut,
  output logic busCtlOe,
  output logic busStatMemr,
  output logic busStatInp,
  output logic busStatOut,
  output logic busStatM1,
  output logic busStatWoN,
  output logic busSyncOut,
  output logic busStvalNOut,
  output logic busDbinOut,
  output logic busWrNOut,
  // bus address and data
  output logic [bpi_pkg::ADDR_W-1:0] busAddrOut,
  output logic busAddrOe,
  output logic [bpi_pkg::DATA_W-1:0] busDataOut,
  output logic busDataOe,
  // open-drain reset and ready lines (value low, enable pulls)
  output logic busResetNOut,
  output logic busResetOe,
  output logic busPocNOut,
  output logic busPocOe,
  output logic busSlvClrNOut,
  output logic busSlvClrOe,
  output logic busRdyNOut,
  output logic busRdyOe,
  // bus inputs
  input wire logic busPhiIn,
  input wire logic busSyncIn,
  input wire logic busStvalNIn,
  input wire logic busStatMemrIn,
  input wire logic busStatWoNIn,
  input wire logic busDbinIn,
  input wire logic busWrNIn,
  input wire logic [bpi_pkg::ADDR_W-1:0] busAddrIn,
  input wire logic [bpi_pkg::DATA_W-1:0] busDataIn,
  input wire logic busResetNIn,
  input wire logic busSlvClrNIn
);
  localparam int CHAIN = bpi_pkg::CHAIN_DEPTH;
  localparam int SYNC_W = 12 + bpi_pkg::WAIT_W + bpi_pkg::SEL_W + bpi_pkg::ADDR_W + bpi_pkg::DATA_W;

  initial begin
    if (SETTLE_CYC < 1) $error("settle count must be positive");
    if (RAM_AW != bpi_pkg::CPU_ADDR_W) $error("ram must cover the 64K slave window");
  end

  //////////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers for every strap, switch, power, reset and bus input; processor side inputs are used directly
  logic [SYNC_W-1:0] syncA, syncB;
  logic masterMode, pwrOk, btnN, wFit, phiS, syncS, stvalNS, memrS, woNS, dbinS, wrNS, rstNS, slvClrNS;
  logic [bpi_pkg::WAIT_W-1:0] waitS;
  logic [bpi_pkg::SEL_W-1:0] selS;
  logic [bpi_pkg::ADDR_W-1:0] addrS;
  logic [bpi_pkg::DATA_W-1:0] dataS;

  always_ff @(posedge clk) begin
    syncA <= {masterSlaveSelectStrap, pwrGood, resetBtnN, slaveWaitFitted, busPhiIn, busSyncIn,
              busStvalNIn, busStatMemrIn, busStatWoNIn, busDbinIn, busWrNIn, busResetNIn,
              slaveWaitCountStrap, boardSelSwitch, busAddrIn, busDataIn};
    syncB <= syncA;
  end

  // static strap: one level selects the whole interface mode
  assign {masterMode, pwrOk, btnN, wFit, phiS, syncS, stvalNS, memrS, woNS, dbinS, wrNS, rstNS,
          waitS, selS, addrS, dataS} = syncB;

  // slave clear is synced separately to keep the wide vector readable
  logic slvClrA;
  always_ff @(posedge clk) begin
    slvClrA <= busSlvClrNIn;
    slvClrNS <= slvClrA;
  end

  //////////////////////////////////////////////////////////////////////////////
  // processor clock divider and inverted bus clock
  logic [3:0] divCnt, next_divCnt;
  logic next_procClk, procFall;

  always_comb begin
    next_divCnt = divCnt + 4'h1;
    next_procClk = procClk;
    procFall = 1'b0;
    if (divCnt == 4'(bpi_pkg::PROC_HALF_CYC - 1)) begin
      next_divCnt = 4'h0;
      next_procClk = ~procClk;
      procFall = procClk;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      divCnt <= 4'h0;
      procClk <= 1'b0;
    end else begin
      divCnt <= next_divCnt;
      procClk <= next_procClk;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // master bus timing: gates build status, the chain shifts on processor falls
  logic cycAct;
  logic [CHAIN-1:0] taps;
  logic [bpi_pkg::LOW_ADDR_W-1:0] lowHold, next_lowHold;

  assign cycAct = ~cpuMreqN | ~cpuIorqN;

  bpi_tap_chain #(.DEPTH(CHAIN)) uChain (
    .clk(clk),
    .srst(srst),
    .shiftEn(procFall),
    .din(cycAct),
    .taps(taps)
  );

  // low address bits are latched at cycle start and held until the hold tap
  // drops, so they never tear mid-cycle; the mapper bits are not held and follow mapAddr every clock
  always_comb begin
    next_lowHold = lowHold;
    if (cycAct && !taps[bpi_pkg::TAP_SYNC]) begin
      next_lowHold = cpuAddr[bpi_pkg::LOW_ADDR_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      lowHold <= '0;
      busPhiOut <= 1'b0;
      busCtlOe <= 1'b0;
      busStatMemr <= 1'b0;
      busStatInp <= 1'b0;
      busStatOut <= 1'b0;
      busStatM1 <= 1'b0;
      busStatWoN <= 1'b1;
      busSyncOut <= 1'b0;
      busStvalNOut <= 1'b1;
      busDbinOut <= 1'b0;
      busWrNOut <= 1'b1;
      busAddrOut <= bpi_pkg::ADDR_ZERO;
      busAddrOe <= 1'b0;
    end else begin
      lowHold <= next_lowHold;
      busPhiOut <= ~procClk;
      busCtlOe <= masterMode;
      busAddrOe <= masterMode;
      busStatMemr <= ~cpuMreqN & (~cpuRdN | ~cpuM1N);
      busStatInp <= ~cpuIorqN & ~cpuRdN;
      busStatOut <= ~cpuIorqN & ~cpuWrN;
      busStatM1 <= ~cpuM1N;
      busStatWoN <= cpuWrN;
      busSyncOut <= taps[bpi_pkg::TAP_SYNC] & ~taps[bpi_pkg::TAP_STVAL];
      busStvalNOut <= ~(taps[bpi_pkg::TAP_STVAL] & ~taps[bpi_pkg::TAP_HOLD]);
      busDbinOut <= ~cpuRdN;
      busWrNOut <= cpuWrN | cpuMreqN;
      busAddrOut <= {mapAddr, (cycAct || taps[bpi_pkg::TAP_HOLD]) ? next_lowHold
                     : cpuAddr[bpi_pkg::LOW_ADDR_W-1:0]};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // power-on clear and reset sequencing
  logic [31:0] settleCnt, next_settleCnt;
  logic resetHold;

  always_comb begin
    next_settleCnt = settleCnt;
    if (!pwrOk || !btnN) begin
      next_settleCnt = '0;
    end else if (settleCnt < 32'(SETTLE_CYC)) begin
      next_settleCnt = settleCnt + 32'h1;
    end
  end
  assign resetHold = settleCnt < 32'(SETTLE_CYC);

  always_ff @(posedge clk) begin
    if (srst) begin
      settleCnt <= '0;
      busResetOe <= 1'b0;
      busPocOe <= 1'b0;
      busSlvClrOe <= 1'b0;
      boardRst <= 1'b1;
    end else begin
      settleCnt <= next_settleCnt;
      busResetOe <= masterMode & resetHold;
      busPocOe <= masterMode & resetHold;
      busSlvClrOe <= masterMode & resetHold;
      boardRst <= masterMode ? resetHold : (~slvClrNS | ~rstNS);
    end
  end
  assign busResetNOut = 1'b0;
  assign busPocNOut = 1'b0;
  assign busSlvClrNOut = 1'b0;
  assign busRdyNOut = 1'b0;

  //////////////////////////////////////////////////////////////////////////////
  // slave decode and wait generator, all gated off in master mode
  bpi_pkg::bpi_slv_e state, next_state;
  logic [bpi_pkg::WAIT_W-1:0] waitCnt, next_waitCnt, waitSel;
  logic phiD, busTick, syncD, cycStart, hit, slvActive;
  logic ramEn, ramWe;
  logic [RAM_AW-1:0] ramAddr;
  logic [bpi_pkg::DATA_W-1:0] ramWdata, ramRdata;

  always_ff @(posedge clk) begin
    phiD <= phiS;
    syncD <= syncS;
  end
  localparam int CPU_SHIFT = bpi_pkg::CPU_ADDR_W;
  assign busTick = phiS & ~phiD;
  // only a memory read or a write-out cycle inside the RAM window is decoded; no ROM decode exists
  assign hit = (addrS[bpi_pkg::ADDR_W-1:CPU_SHIFT] == selS) & (memrS | ~woNS);
  assign cycStart = ~masterMode & syncS & ~syncD & hit;
  assign waitSel = !wFit ? bpi_pkg::WAIT_NONE
                 : (waitS > bpi_pkg::WAIT_MAX ? bpi_pkg::WAIT_MAX : waitS);

  always_comb begin
    next_state = state;
    next_waitCnt = waitCnt;
    case (state)
      bpi_pkg::SLV_IDLE: begin
        if (cycStart) begin
          next_waitCnt = waitSel;
          next_state = bpi_pkg::SLV_WAIT;
        end
      end
      bpi_pkg::SLV_WAIT: begin
        if (waitCnt == bpi_pkg::WAIT_NONE) begin
          next_state = bpi_pkg::SLV_DONE;
        end else if (busTick) begin
          next_waitCnt = waitCnt - 3'h1;
        end
      end
      bpi_pkg::SLV_DONE: begin
        if (!syncS && stvalNS) begin
          next_state = bpi_pkg::SLV_IDLE;
        end
      end
      default: begin
        next_state = bpi_pkg::SLV_IDLE;
      end
    endcase
    if (masterMode || boardRst) begin
      next_state = bpi_pkg::SLV_IDLE;
      next_waitCnt = bpi_pkg::WAIT_NONE;
    end
  end

  assign slvActive = (state != bpi_pkg::SLV_IDLE);
  // bus owns the RAM during a slave cycle; the cpu port is locked out meanwhile
  assign ramEn = slvActive ? (dbinS | ~wrNS) : cpuRamSel & (~cpuRdN | ~cpuWrN);
  assign ramWe = slvActive ? ~wrNS : ~cpuWrN;
  assign ramAddr = slvActive ? addrS[RAM_AW-1:0] : cpuAddr[RAM_AW-1:0];
  assign ramWdata = slvActive ? dataS : cpuWdata;

  bpi_ram #(.AW(RAM_AW), .DW(bpi_pkg::DATA_W)) uRam (
    .clk(clk),
    .en(ramEn),
    .we(ramWe),
    .addr(ramAddr),
    .wdata(ramWdata),
    .rdata(ramRdata)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= bpi_pkg::SLV_IDLE;
      waitCnt <= bpi_pkg::WAIT_NONE;
      busRdyOe <= 1'b0;
      busDataOut <= bpi_pkg::DATA_ZERO;
      busDataOe <= 1'b0;
      cpuRdata <= bpi_pkg::DATA_ZERO;
    end else begin
      state <= next_state;
      waitCnt <= next_waitCnt;
      busRdyOe <= (next_state == bpi_pkg::SLV_WAIT) & (next_waitCnt != bpi_pkg::WAIT_NONE);
      busDataOut <= masterMode ? cpuWdata : ramRdata;
      busDataOe <= masterMode ? (cycAct & ~cpuWrN) : (slvActive & dbinS);
      cpuRdata <= (masterMode && !cpuRamSel) ? dataS : ramRdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_phi_inv;
    procClk |=> !busPhiOut;
  endproperty
  a_phi_inv: assert property (p_phi_inv) else $error("bus clock not inverted");

  property p_memr;
    (!cpuMreqN && !cpuRdN) |=> busStatMemr;
  endproperty
  a_memr: assert property (p_memr) else $error("memory read status missing");

  property p_sync_tap;
    $fell(busSyncOut) |-> !busStvalNOut && $past(busStvalNOut);
  endproperty
  a_sync_tap: assert property (p_sync_tap) else $error("strobe does not follow sync");

  property p_high_addr;
    1'b1 |=> busAddrOut[bpi_pkg::ADDR_W-1:bpi_pkg::LOW_ADDR_W] == $past(mapAddr);
  endproperty
  a_high_addr: assert property (p_high_addr) else $error("upper address not from mapper");

  property p_slave_tri;
    !masterMode |=> !busCtlOe && !busAddrOe;
  endproperty
  a_slave_tri: assert property (p_slave_tri) else $error("slave drives control lines");

  property p_reset_hold;
    (masterMode && !pwrOk) |=> ##1 busResetOe;
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("bus reset released early");

  property p_reset_slave;
    !masterMode |=> !busResetOe && !busPocOe && !busSlvClrOe;
  endproperty
  a_reset_slave: assert property (p_reset_slave) else $error("slave drives reset lines");

  property p_slvclr;
    (!masterMode && !slvClrNS) |=> boardRst;
  endproperty
  a_slvclr: assert property (p_slvclr) else $error("slave clear ignored");

  property p_rdy_zero;
    (cycStart && waitSel == bpi_pkg::WAIT_NONE && state == bpi_pkg::SLV_IDLE) |=> !busRdyOe [*2];
  endproperty
  a_rdy_zero: assert property (p_rdy_zero) else $error("wait sent with zero count");

  property p_rdy_hold;
    (cycStart && state == bpi_pkg::SLV_IDLE && waitSel != bpi_pkg::WAIT_NONE && !boardRst) |=> busRdyOe;
  endproperty
  a_rdy_hold: assert property (p_rdy_hold) else $error("ready not pulled at cycle start");

  property p_master_idle;
    masterMode |=> state == bpi_pkg::SLV_IDLE && !busRdyOe;
  endproperty
  a_master_idle: assert property (p_master_idle) else $error("slave logic active in master");
endmodule

//--- bpi_bus_model.sv
// behavioural backplane master card that runs memory cycles at a slave
module bpi_bus_model (
  // clock
  input wire logic clk,
  // commands
  input wire logic go,
  input wire logic wr,
  input wire logic [23:0] adr,
  input wire logic [7:0] wdat,
  input wire logic clrReq,
  // bus lines
  input wire logic rdyN,
  input wire logic [7:0] dutDat,
  input wire logic dutDatOe,
  output logic phi,
  output logic sync,
  output logic stvalN,
  output logic memr,
  output logic woN,
  output logic dbin,
  output logic wrN,
  output logic [23:0] adrOut,
  output logic [7:0] datOut,
  output logic slvClrN,
  // results
  output logic busy,
  output logic [7:0] rdat,
  output int lowCnt
);
  timeunit 1ns;
  timeprecision 1ns;
  int k;
  logic [1:0] phiCnt;
  assign slvClrN = !clrReq;
  assign phi = phiCnt[1];
  initial begin
    phiCnt = 2'h0;
    sync = 1'b0;
    stvalN = 1'b1;
    memr = 1'b0;
    woN = 1'b1;
    dbin = 1'b0;
    wrN = 1'b1;
    adrOut = 24'h000000;
    datOut = 8'h00;
    busy = 1'b0;
    rdat = 8'h00;
    lowCnt = 0;
  end
  ////////////////////////////////////////
  // bus clock runs free, as a master's clock does
  always @(posedge clk) begin
    phiCnt <= phiCnt + 2'h1;
  end
  always @(posedge clk) begin
    if (go === 1'b1) begin
      lowCnt <= 0;
    end else if (busy && rdyN === 1'b0) begin
      lowCnt <= lowCnt + 1;
    end
  end
  ////////////////////////////////////////
  always begin
    @(posedge clk);
    if (go !== 1'b1) begin
      // released lines keep changing so stale values cannot pass for data
      adrOut <= ~adrOut;
      datOut <= ~datOut;
    end else begin
      busy <= 1'b1;
      // a master starts its cycles on a fixed phase of its own clock
      while (phiCnt != 2'h0) begin
        @(posedge clk);
      end
      adrOut <= adr;
      datOut <= wdat;
      memr <= !wr;
      woN <= !wr;
      dbin <= !wr;
      sync <= 1'b1;
      repeat (4) @(posedge clk);
      sync <= 1'b0;
      stvalN <= 1'b0;
      wrN <= !wr;
      repeat (4) @(posedge clk);
      k = 0;
      while (rdyN === 1'b0 && k < 200) begin
        @(posedge clk);
        k++;
      end
      rdat <= dutDatOe ? dutDat : 8'h00;
      stvalN <= 1'b1;
      memr <= 1'b0;
      woN <= 1'b1;
      dbin <= 1'b0;
      wrN <= 1'b1;
      busy <= 1'b0;
    end
  end
endmodule

//--- testbench.sv
// self-checking bench for the backplane bus interface
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SET = 20;
  localparam logic [4:0] CMD [5] = '{5'h0b, 5'h0a, 5'h0d, 5'h13, 5'h15};
  localparam logic [5:0] EXP [5] = '{6'h23, 6'h27, 6'h00, 6'h13, 6'h09};
  logic clk, srst, masterSlaveSelectStrap, slaveWaitFitted, pwrGood, resetBtnN;
  logic [2:0] slaveWaitCountStrap;
  logic [7:0] boardSelSwitch, cpuWdata, cpuRdata, busDataOut, busDataIn, mWd, mDat, rdat;
  logic cpuMreqN, cpuIorqN, cpuRdN, cpuWrN, cpuM1N, cpuRamSel;
  logic [15:0] cpuAddr;
  logic [11:0] mapAddr;
  logic procClk, boardRst, busPhiOut, busCtlOe, busStatMemr, busStatInp, busStatOut, busStatM1;
  logic busStatWoN, busSyncOut, busStvalNOut, busDbinOut, busWrNOut, busAddrOe, busDataOe;
  logic busResetOe, busPocOe, busSlvClrOe, busRdyOe, go, mWr, clrReq, busy, mSlvClrN;
  logic busPhiIn, busSyncIn, busStvalNIn, busStatMemrIn, busStatWoNIn, busDbinIn, busWrNIn;
  logic busResetNIn, busSlvClrNIn;
  logic [23:0] busAddrOut, busAddrIn, mAdr;
  int lowCnt, nFail, cmpCount, cyc;
  assign busDataIn = busDataOe ? busDataOut : mDat;
  assign busResetNIn = !busResetOe;
  assign busSlvClrNIn = mSlvClrN & !busSlvClrOe;
  bpi_bus_if #(.SETTLE_CYC(SET)) u_dut (
    .clk, .srst, .masterSlaveSelectStrap, .slaveWaitFitted, .slaveWaitCountStrap, .boardSelSwitch,
    .pwrGood, .resetBtnN, .cpuMreqN, .cpuIorqN, .cpuRdN, .cpuWrN, .cpuM1N, .cpuRamSel, .cpuAddr,
    .cpuWdata, .mapAddr, .procClk, .boardRst, .cpuRdata, .busPhiOut, .busCtlOe, .busStatMemr,
    .busStatInp, .busStatOut, .busStatM1, .busStatWoN, .busSyncOut, .busStvalNOut, .busDbinOut,
    .busWrNOut, .busAddrOut, .busAddrOe, .busDataOut, .busDataOe, .busResetNOut(), .busResetOe,
    .busPocNOut(), .busPocOe, .busSlvClrNOut(), .busSlvClrOe, .busRdyNOut(), .busRdyOe, .busPhiIn,
    .busSyncIn, .busStvalNIn, .busStatMemrIn, .busStatWoNIn, .busDbinIn, .busWrNIn, .busAddrIn,
    .busDataIn, .busResetNIn, .busSlvClrNIn);
  bpi_bus_model u_bus (
    .clk, .go, .wr(mWr), .adr(mAdr), .wdat(mWd), .clrReq, .rdyN(!busRdyOe), .dutDat(busDataOut),
    .dutDatOe(busDataOe), .phi(busPhiIn), .sync(busSyncIn), .stvalN(busStvalNIn), .memr(busStatMemrIn),
    .woN(busStatWoNIn), .dbin(busDbinIn), .wrN(busWrNIn), .adrOut(busAddrIn), .datOut(mDat),
    .slvClrN(mSlvClrN), .busy, .rdat, .lowCnt);
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp) begin
      nFail++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic printVerdict;
    if (nFail == 0 && cmpCount > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // straps are static, so every change goes through a reset
  task automatic doReset;
    srst <= 1'b1;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
  endtask
  task automatic waitRst(input logic lvl);
    int n;
    n = 0;
    while (boardRst !== lvl && n < 200) begin
      @(posedge clk);
      n++;
    end
    chk(boardRst, lvl);
  endtask
  task automatic busCycle(input logic w, input logic [23:0] a, input logic [7:0] d);
    int n;
    mWr <= w;
    mAdr <= a;
    mWd <= d;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    n = 0;
    while (busy === 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk(busy, 1'b0);
    @(posedge clk);
  endtask
  ////////////////////////////////////////
  task automatic tPower;
    int n;
    repeat (6) @(posedge clk);
    chk({busResetOe, busPocOe, busSlvClrOe, boardRst}, 4'hf);
    pwrGood <= 1'b1;
    n = 0;
    while (busResetOe !== 1'b0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk(n >= SET && n <= SET + 8, 1'b1);
    chk({busResetOe, busPocOe, busSlvClrOe}, 3'h0);
    waitRst(1'b0);
  endtask
  task automatic tPhase;
    logic prev;
    chk({busCtlOe, busAddrOe}, 2'h3);
    prev = procClk;
    repeat (8) begin
      @(posedge clk);
      chk(busPhiOut, !prev);
      prev = procClk;
    end
  endtask
  task automatic tStatus;
    for (int i = 0; i < 5; i++) begin
      {cpuMreqN, cpuIorqN, cpuRdN, cpuWrN, cpuM1N} <= CMD[i];
      repeat (3) @(posedge clk);
      chk({busStatMemr, busStatInp, busStatOut, busStatM1, busDbinOut, busWrNOut}, EXP[i]);
      chk(busStatWoN, CMD[i][1]);
    end
    {cpuMreqN, cpuIorqN, cpuRdN, cpuWrN, cpuM1N} <= 5'h1f;
    repeat (12) @(posedge clk);
  endtask
  task automatic tChain;
    int n;
    mapAddr <= 12'ha5c;
    cpuAddr <= 16'h3123;
    {cpuMreqN, cpuRdN} <= 2'b00;
    n = 0;
    while (busSyncOut !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk(busAddrOut, 24'ha5c123);
    cpuAddr <= 16'h3fff;
    n = 0;
    while (busSyncOut === 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk(n, 4);
    chk(busAddrOut[11:0], 12'h123);
    n = 0;
    while (busStvalNOut === 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk(n, 4);
    {cpuMreqN, cpuRdN} <= 2'b11;
    repeat (12) @(posedge clk);
  endtask
  task automatic tSlave;
    int e, first;
    busCycle(1'b0, {boardSelSwitch, 16'h0040}, 8'h00);
    chk(lowCnt, 0);
    chk(rdat, 8'h00);
    masterSlaveSelectStrap <= 1'b0;
    pwrGood <= 1'b0;
    doReset;
    repeat (6) @(posedge clk);
    chk({busCtlOe, busAddrOe, busResetOe, busPocOe, busSlvClrOe}, 5'h00);
    pwrGood <= 1'b1;
    for (int n = 0; n <= 8; n++) begin
      slaveWaitFitted <= (n < 8);
      slaveWaitCountStrap <= (n < 8) ? 3'(n) : 3'h5;
      doReset;
      waitRst(1'b0);
      busCycle(1'b0, {boardSelSwitch, 16'h0100}, 8'h00);
      first = lowCnt;
      busCycle(1'b0, {boardSelSwitch, 16'h0101}, 8'h00);
      chk(lowCnt, first);
      e = (n > 7) ? 0 : (n > 5) ? 5 : n;
      chk(first >= (e ? 4 * e - 3 : 0) && first <= (e ? 4 * e + 4 : 0), 1'b1);
    end
  endtask
  task automatic tRam;
    slaveWaitFitted <= 1'b1;
    slaveWaitCountStrap <= 3'h2;
    doReset;
    waitRst(1'b0);
    busCycle(1'b1, {boardSelSwitch, 16'h8123}, 8'h5a);
    busCycle(1'b1, {boardSelSwitch + 8'h01, 16'h8123}, 8'hc3);
    chk(lowCnt, 0);
    busCycle(1'b0, {boardSelSwitch + 8'h01, 16'h8123}, 8'h00);
    chk(rdat, 8'h00);
    busCycle(1'b0, {boardSelSwitch, 16'h8123}, 8'h00);
    chk(rdat, 8'h5a);
    chk(lowCnt >= 5 && lowCnt <= 12, 1'b1);
    cpuAddr <= 16'h8123;
    cpuRamSel <= 1'b1;
    {cpuMreqN, cpuRdN} <= 2'b00;
    repeat (3) @(posedge clk);
    chk(cpuRdata, 8'h5a);
    {cpuMreqN, cpuRdN} <= 2'b11;
    cpuRamSel <= 1'b0;
    clrReq <= 1'b1;
    waitRst(1'b1);
    chk(busSlvClrOe, 1'b0);
    clrReq <= 1'b0;
    waitRst(1'b0);
  endtask
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      nFail++;
      printVerdict;
    end
  end
  initial begin
    {srst, masterSlaveSelectStrap, slaveWaitFitted, resetBtnN} = 4'hf;
    {cpuMreqN, cpuIorqN, cpuRdN, cpuWrN, cpuM1N} = 5'h1f;
    {pwrGood, cpuRamSel, go, mWr, clrReq} = 5'h0;
    slaveWaitCountStrap = 3'h3;
    boardSelSwitch = 8'h3c;
    cpuWdata = 8'h00;
    cpuAddr = 16'h0000;
    mapAddr = 12'h000;
    mAdr = 24'h000000;
    mWd = 8'h00;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    tPower;
    tPhase;
    tStatus;
    tChain;
    tSlave;
    tRam;
    printVerdict;
  end
endmodule
